// ### rtl/tx_link_serial_in_pkg.sv
// constants, types and register map of the transmit data-link and alarm block
// assumes a 10 MHz hclk and an AHB-Lite master with 32-bit single transfers
package link_alarm_pkg;
    localparam int CLK_NS = 100;
    localparam int LINK_BIT_NS = 488;
    localparam int LINK_BIT_CYC = (LINK_BIT_NS + CLK_NS - 1) / CLK_NS;
    localparam int FRAME_BITS = 256;
    localparam int SA_FIRST = 3;
    localparam int SA_NUM = 5;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_NAT_SEL = 8'h00;
    localparam logic [7:0] IDX_MODE_STAT = 8'h01;
    localparam logic [7:0] IDX_IRQ_STAT = 8'h02;
    localparam logic [7:0] IDX_IRQ_CLR = 8'h03;
    localparam logic [7:0] IDX_IRQ_EN = 8'h04;
    localparam logic [7:0] IDX_CTRL = 8'h13;
    localparam logic [7:0] IDX_LINE_STAT = 8'h18;
    localparam int CTRL_SRC_SEL_BIT = 2;
    localparam int LINE_STAT_LOSS_BIT = 4;
    localparam int LINE_STAT_FRAME_BIT = 0;
    localparam logic [4:0] NAT_SEL_RST = 5'h01;
    localparam int IRQ_W = 3;
    localparam int EV_LOSS = 0;
    localparam int EV_ALARM = 1;
    localparam int EV_MODE = 2;
    typedef enum logic [1:0] {
        MODE_FREE_RUN = 2'b00,
        MODE_LINE_SYNC = 2'b01,
        MODE_BUS_SYNC = 2'b10
    } timing_mode_t;
endpackage

// ### rtl/pin_sync.sv
// two-stage synchroniser for a group of pin inputs
// assumes the pins are asynchronous to hclk; ce freezes both stages
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic hclk, // block clock
    input wire logic hresetn, // async reset, active low
    input wire logic ce, // clock enable
    input wire logic [W-1:0] pin_in, // raw pins
    output logic [W-1:0] pin_sync_out // synchronised level
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } sync_state_t;
    sync_state_t st_ff, nxt_st;

    // the first stage feeds the second and nothing else
    always_comb begin
        nxt_st = st_ff;
        if (ce) begin
            nxt_st.meta = pin_in;
            nxt_st.stable = st_ff.meta;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_ff <= '{meta: RST_VAL, stable: RST_VAL};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign pin_sync_out = st_ff.stable;
endmodule

// ### rtl/frame_slot_gen.sv
// bit and frame position counter driven by edges of the sampled line clock
// assumes line_clk_s is already synchronised to hclk
`timescale 1ns/1ps
module frame_slot_gen
    import link_alarm_pkg::*;
(
    input wire logic hclk, // block clock
    input wire logic hresetn, // async reset, active low
    input wire logic ce, // clock enable
    input wire logic line_clk_s, // synchronised line bit clock
    output logic rise_tick, // one-cycle pulse, line clock rose
    output logic fall_tick, // one-cycle pulse, line clock fell
    output logic [7:0] bit_pos, // position of the bit starting now
    output logic odd_frame // frame without alignment word
);
    typedef struct packed {
        logic prev;
        logic [7:0] cnt;
        logic odd;
    } slot_state_t;
    slot_state_t st_ff, nxt_st;

    assign rise_tick = ce & line_clk_s & ~st_ff.prev;
    assign fall_tick = ce & ~line_clk_s & st_ff.prev;
    assign bit_pos = st_ff.cnt;
    assign odd_frame = st_ff.odd;

    // free-running count; no alignment to a received frame is attempted
    always_comb begin
        nxt_st = st_ff;
        if (ce) begin
            nxt_st.prev = line_clk_s;
        end
        if (rise_tick) begin
            nxt_st.cnt = st_ff.cnt + 8'h01;
            if (st_ff.cnt == 8'(FRAME_BITS - 1)) begin
                nxt_st.odd = ~st_ff.odd;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_ff <= '{prev: 1'b0, cnt: 8'h00, odd: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end
endmodule

// ### rtl/tx_datalink_alarm_status.sv
// transmit data-link insertion, alarm forcing, loss status and timing mode
// assumes an AHB-Lite master on hclk and pins asynchronous to hclk
`timescale 1ns/1ps
module tx_datalink_alarm_status
    import link_alarm_pkg::*;
(
    input wire logic hclk, // 10 MHz block clock
    input wire logic hresetn, // async reset, active low
    input wire logic ce, // clock enable, freezes all state when low
    input wire logic hsel, // slave select
    input wire logic [31:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write when high
    input wire logic [2:0] hsize, // transfer size
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready
    output logic [31:0] hrdata, // read data
    output logic hreadyout, // slave ready
    output logic hresp, // always okay
    input wire logic line_clk, // 2.048 MHz line bit clock pin
    input wire logic tx_payload_in, // outgoing frame bit, valid on rise_tick
    input wire logic tx_alarm_force_n, // alarm pin, active low
    input wire logic tx_link_serial_in, // serial data-link pin
    output logic tx_link_gapped_clk, // gapped data-link clock
    output logic line_out_pos, // positive line mark
    output logic line_out_neg, // negative line mark
    input wire logic line_signal_loss_flag, // signal loss from line receiver
    input wire logic frame_loss_flag, // frame alignment loss from framer
    output logic loss_status_out, // loss status pin
    input wire logic timing_mode_sel, // bus-or-line / free-run pin
    input wire logic sync_source_sel, // bus / line sync pin
    input wire logic system_clock_4m_i, // system clock pin, input side
    output logic system_clock_4m_o, // system clock pin, output side
    output logic system_clock_4m_oe, // system clock pin, drive enable
    input wire logic clk_4m_gen, // locally generated 4.096 MHz clock
    output logic irq // level interrupt
);
    typedef struct packed {
        logic ph_valid;
        logic ph_write;
        logic [7:0] ph_idx;
        logic [31:0] rdata;
        logic [4:0] nat_sel;
        logic src_sel;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_en;
        logic gclk;
        logic line_bit;
        logic mark_neg;
        logic pos;
        logic neg;
        logic loss;
        logic alarm_prev;
        timing_mode_t mode;
        logic clk_oe;
        logic clk_out;
        logic ext_clk_prev;
        logic ext_clk_seen;
    } blk_state_t;
    blk_state_t st_ff, nxt_st;

    logic [4:0] pins_s;
    logic alarm_n_s, ser_s, mode_s, src_s, line_clk_s, ext_clk_s;
    logic rise_tick, fall_tick, odd_frame, in_sa, sel_hit;
    logic [7:0] bit_pos;
    logic [2:0] sa_idx;
    logic [IRQ_W-1:0] ev;
    logic [IRQ_W-1:0] clr;
    logic ph_take;
    timing_mode_t mode_next;
    logic loss_next;

    // all pins but the loss flags, payload and generated clock pass two flops before use
    // reset values match idle pins, so no false line edge or mode event follows reset
    pin_sync #(.W(5), .RST_VAL(5'h18)) u_pins (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .pin_in({tx_alarm_force_n, tx_link_serial_in, timing_mode_sel,
                 sync_source_sel, line_clk}),
        .pin_sync_out(pins_s)
    );
    pin_sync #(.W(1), .RST_VAL(1'b0)) u_extclk (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .pin_in(system_clock_4m_i),
        .pin_sync_out(ext_clk_s)
    );
    assign {alarm_n_s, ser_s, mode_s, src_s, line_clk_s} = pins_s;

    frame_slot_gen u_slots (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .line_clk_s(line_clk_s),
        .rise_tick(rise_tick),
        .fall_tick(fall_tick),
        .bit_pos(bit_pos),
        .odd_frame(odd_frame)
    );

    // national bits sit in positions 3..7 of the non-alignment frame
    assign sa_idx = 3'(bit_pos - 8'(SA_FIRST));
    assign in_sa = odd_frame && bit_pos >= 8'(SA_FIRST) && bit_pos < 8'(SA_FIRST + SA_NUM);
    assign sel_hit = rise_tick && in_sa && st_ff.nat_sel[sa_idx];

    // mode decode: high pin picks bus or line sync, low pin free run
    always_comb begin
        if (!mode_s) begin
            mode_next = MODE_FREE_RUN;
        end else if (src_s) begin
            mode_next = MODE_BUS_SYNC;
        end else begin
            mode_next = MODE_LINE_SYNC;
        end
    end

    // loss status source; kept out of the state process so the event logic can read it
    always_comb begin
        if (st_ff.src_sel) begin
            loss_next = line_signal_loss_flag;
        end else begin
            loss_next = line_signal_loss_flag | frame_loss_flag;
        end
    end

    assign ph_take = hsel && hready && htrans[1];
    assign clr = (st_ff.ph_valid && st_ff.ph_write && st_ff.ph_idx == IDX_IRQ_CLR) ?
                 hwdata[IRQ_W-1:0] : '0;
    assign ev[EV_LOSS] = ce && !st_ff.loss && loss_next;
    assign ev[EV_ALARM] = ce && st_ff.alarm_prev && !alarm_n_s;
    assign ev[EV_MODE] = ce && st_ff.mode != mode_next;

    // next-state of the whole block
    always_comb begin
        nxt_st = st_ff;
        if (ce) begin
            // bus address phase: read data is prepared here, written in data phase
            nxt_st.ph_valid = ph_take;
            nxt_st.ph_write = hwrite;
            nxt_st.ph_idx = haddr[9:2];
            if (ph_take && !hwrite) begin
                unique case (haddr[9:2])
                    IDX_NAT_SEL: nxt_st.rdata = {27'h0, st_ff.nat_sel};
                    IDX_MODE_STAT: nxt_st.rdata = {28'h0, st_ff.ext_clk_seen, st_ff.clk_oe,
                                                   st_ff.mode};
                    IDX_IRQ_STAT: nxt_st.rdata = {29'h0, st_ff.irq_stat};
                    IDX_IRQ_EN: nxt_st.rdata = {29'h0, st_ff.irq_en};
                    IDX_CTRL: nxt_st.rdata = 32'(st_ff.src_sel) << CTRL_SRC_SEL_BIT;
                    IDX_LINE_STAT: nxt_st.rdata = (32'(line_signal_loss_flag)
                                                   << LINE_STAT_LOSS_BIT)
                                                  | (32'(frame_loss_flag)
                                                     << LINE_STAT_FRAME_BIT);
                    default: nxt_st.rdata = 32'h0000_0000;
                endcase
            end
            if (st_ff.ph_valid && st_ff.ph_write) begin
                unique case (st_ff.ph_idx)
                    IDX_NAT_SEL: nxt_st.nat_sel = hwdata[4:0];
                    IDX_IRQ_EN: nxt_st.irq_en = hwdata[IRQ_W-1:0];
                    IDX_CTRL: nxt_st.src_sel = hwdata[CTRL_SRC_SEL_BIT];
                    default: nxt_st.nat_sel = st_ff.nat_sel;
                endcase
            end

            // loss status follows the selected source one edge later
            nxt_st.loss = loss_next;

            // gapped clock rises at a selected slot and falls mid cell
            if (sel_hit) begin
                nxt_st.gclk = 1'b1;
            end else if (fall_tick) begin
                nxt_st.gclk = 1'b0;
            end

            // line bit: link bit in chosen slots, all ones while alarm forced
            if (rise_tick) begin
                if (!alarm_n_s) begin
                    nxt_st.line_bit = 1'b1;
                end else if (sel_hit) begin
                    nxt_st.line_bit = ser_s;
                end else begin
                    nxt_st.line_bit = tx_payload_in;
                end
            end
            // alternate mark encoding so successive ones go to line_out_pos and line_out_neg in turn
            if (fall_tick) begin
                nxt_st.pos = st_ff.line_bit & ~st_ff.mark_neg;
                nxt_st.neg = st_ff.line_bit & st_ff.mark_neg;
                nxt_st.mark_neg = st_ff.mark_neg ^ st_ff.line_bit;
            end

            // timing mode and system clock direction
            nxt_st.mode = mode_next;
            nxt_st.clk_oe = mode_next != MODE_BUS_SYNC;
            nxt_st.clk_out = clk_4m_gen;
            nxt_st.ext_clk_prev = ext_clk_s;
            if (st_ff.mode == MODE_BUS_SYNC && ext_clk_s && !st_ff.ext_clk_prev) begin
                nxt_st.ext_clk_seen = 1'b1;
            end else if (st_ff.mode != MODE_BUS_SYNC) begin
                nxt_st.ext_clk_seen = 1'b0;
            end
            nxt_st.alarm_prev = alarm_n_s;
            // a new event beats a clear in the same cycle; a frozen clear must not repeat
            nxt_st.irq_stat = (st_ff.irq_stat & ~clr) | ev;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_ff <= '{ph_valid: 1'b0, ph_write: 1'b0, ph_idx: 8'h00, rdata: 32'h0,
                       nat_sel: NAT_SEL_RST, src_sel: 1'b0, irq_stat: '0, irq_en: '0,
                       gclk: 1'b0, line_bit: 1'b1, mark_neg: 1'b0, pos: 1'b0,
                       neg: 1'b0, loss: 1'b0, alarm_prev: 1'b1, mode: MODE_FREE_RUN,
                       clk_oe: 1'b1, clk_out: 1'b0, ext_clk_prev: 1'b0,
                       ext_clk_seen: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // outputs
    assign hrdata = st_ff.rdata;
    assign hreadyout = 1'b1; // zero wait states
    assign hresp = 1'b0;
    assign tx_link_gapped_clk = st_ff.gclk;
    assign line_out_pos = st_ff.pos;
    assign line_out_neg = st_ff.neg;
    assign loss_status_out = st_ff.loss;
    assign system_clock_4m_o = st_ff.clk_out;
    assign system_clock_4m_oe = st_ff.clk_oe;
    assign irq = |(st_ff.irq_stat & st_ff.irq_en);

    // checks
    property p_alarm_ones;
        @(posedge hclk) disable iff (!hresetn)
        (rise_tick && !alarm_n_s) |=> st_ff.line_bit;
    endproperty
    a_alarm_ones: assert property (p_alarm_ones) else $error("alarm did not force a one");

    property p_src_any;
        @(posedge hclk) disable iff (!hresetn)
        (ce && !st_ff.src_sel && (line_signal_loss_flag || frame_loss_flag))
            |=> loss_status_out;
    endproperty
    a_src_any: assert property (p_src_any) else $error("status missed a loss");

    property p_src_sig;
        @(posedge hclk) disable iff (!hresetn)
        (ce && st_ff.src_sel) |=> (loss_status_out == $past(line_signal_loss_flag));
    endproperty
    a_src_sig: assert property (p_src_sig) else $error("status not signal loss only");

    property p_gclk_rise;
        @(posedge hclk) disable iff (!hresetn)
        $rose(tx_link_gapped_clk) |-> $past(sel_hit);
    endproperty
    a_gclk_rise: assert property (p_gclk_rise) else $error("gapped clock out of slot");

    property p_gclk_fall;
        @(posedge hclk) disable iff (!hresetn)
        (tx_link_gapped_clk && fall_tick) |=> !tx_link_gapped_clk;
    endproperty
    a_gclk_fall: assert property (p_gclk_fall) else $error("gapped clock did not gap");

    property p_sample;
        @(posedge hclk) disable iff (!hresetn)
        (sel_hit && alarm_n_s) |=> (st_ff.line_bit == $past(ser_s)) && tx_link_gapped_clk;
    endproperty
    a_sample: assert property (p_sample) else $error("link bit not inserted");

    property p_mode;
        @(posedge hclk) disable iff (!hresetn)
        (ce && !mode_s) |=> st_ff.mode == MODE_FREE_RUN;
    endproperty
    a_mode: assert property (p_mode) else $error("free run not taken");

    property p_clk_dir;
        @(posedge hclk) disable iff (!hresetn)
        (ce && mode_s && src_s) |=> !system_clock_4m_oe;
    endproperty
    a_clk_dir: assert property (p_clk_dir) else $error("clock pin driven in bus sync");

    property p_mark_one;
        @(posedge hclk) disable iff (!hresetn)
        (fall_tick && st_ff.line_bit) |=> (line_out_pos ^ line_out_neg);
    endproperty
    a_mark_one: assert property (p_mark_one) else $error("mark missing on line");

    property p_src_none;
        @(posedge hclk) disable iff (!hresetn)
        (ce && !line_signal_loss_flag && !frame_loss_flag) |=> !loss_status_out;
    endproperty
    a_src_none: assert property (p_src_none) else $error("status high without loss");

    property p_mode_line;
        @(posedge hclk) disable iff (!hresetn)
        (ce && mode_s && !src_s) |=> st_ff.mode == MODE_LINE_SYNC;
    endproperty
    a_mode_line: assert property (p_mode_line) else $error("line sync not taken");

    property p_clk_drive;
        @(posedge hclk) disable iff (!hresetn)
        (ce && !(mode_s && src_s)) |=> system_clock_4m_oe;
    endproperty
    a_clk_drive: assert property (p_clk_drive) else $error("clock pin not driven");

    property p_no_insert;
        @(posedge hclk) disable iff (!hresetn)
        (rise_tick && alarm_n_s && !sel_hit) |=> (st_ff.line_bit == $past(tx_payload_in));
    endproperty
    a_no_insert: assert property (p_no_insert) else $error("link bit outside slot");
endmodule

// ### verif/link_partner.sv
// serial data-link controller model on the far side of the gapped clock
// assumes gclk idles low and pulses once per selected national bit slot
`timescale 1ns/1ps
module link_partner (
    input wire logic gclk, // gapped clock from the block
    output logic sdata, // serial data toward the block
    output logic last_bit // bit that stood at the last rising edge
);
    logic [7:0] pattern = 8'hb2;
    logic [2:0] idx = 3'h0;
    initial sdata = 1'b0;
    initial last_bit = 1'b0;
    // remember what the block was offered at its sampling edge
    always @(posedge gclk) begin
        last_bit <= sdata;
    end
    // shift on the fall so the next bit is long settled before the rise
    always @(negedge gclk) begin
        idx <= idx + 3'h1;
        sdata <= pattern[idx + 3'h1];
    end
endmodule

// ### verif/testbench.sv
// self-checking bench for the transmit data-link, alarm and status block
// assumes the link partner model and the block as the only AHB-Lite slave
`timescale 1ns/1ps
module testbench;
    import link_alarm_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout, hresp, link_data, last_bit, gclk, pos, neg, loss_out;
    logic clk4_o, clk4_oe, irq;
    logic line_clk = 1'b0;
    logic alarm_n = 1'b1;
    logic loss_flag = 1'b0;
    logic frame_flag = 1'b0;
    logic tm_sel = 1'b0;
    logic ss_sel = 1'b0;
    logic chk_en = 1'b0;
    logic ce_in = 1'b1;
    logic ext_clk = 1'b0;
    logic gen_clk = 1'b0;
    int fail_count = 0;
    int checks = 0;
    int pulses = 0;
    logic [31:0] rd;

    always #50 hclk = ~hclk;
    // link clock starts off phase so its edges never meet hclk edges
    initial begin
        #137;
        forever #400 line_clk = ~line_clk;
    end

    tx_datalink_alarm_status DUT (.hclk(hclk), .hresetn(hresetn), .ce(ce_in), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .line_clk(line_clk), .tx_payload_in(1'b0), .tx_alarm_force_n(alarm_n),
        .tx_link_serial_in(link_data), .tx_link_gapped_clk(gclk), .line_out_pos(pos),
        .line_out_neg(neg), .line_signal_loss_flag(loss_flag), .frame_loss_flag(frame_flag),
        .loss_status_out(loss_out), .timing_mode_sel(tm_sel), .sync_source_sel(ss_sel),
        .system_clock_4m_i(ext_clk), .system_clock_4m_o(clk4_o),
        .system_clock_4m_oe(clk4_oe), .clk_4m_gen(gen_clk), .irq(irq));

    link_partner partner (.gclk(gclk), .sdata(link_data), .last_bit(last_bit));

    task automatic complete_run();
        if (fail_count == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    // bounded wait for the slave to finish the current phase
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 16);
        if (hreadyout !== 1'b1) begin
            fail_count++;
            complete_run();
        end
    endtask

    // one single word transfer; read data lands in rd
    task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {22'h0, idx, 2'b00};
        hwrite <= w;
        wait_ready();
        htrans <= 2'b00;
        hwdata <= d;
        wait_ready();
        rd = hrdata;
    endtask

    // count pulses and check each inserted bit as the gapped clock falls
    always @(posedge gclk) begin
        if (chk_en) begin
            pulses++;
        end
    end
    always @(negedge gclk) begin
        if (chk_en) begin
            #1 chk("line_bit", {31'h0, last_bit}, {31'h0, pos | neg});
        end
    end

    task automatic t_reset();
        bus(1'b0, IDX_NAT_SEL, 32'h0);
        chk("nat_sel", {27'h0, NAT_SEL_RST}, rd);
        bus(1'b0, IDX_IRQ_EN, 32'h0);
        chk("irq_en", 32'h0, rd);
        bus(1'b1, 8'h20, 32'hffffffff);
        bus(1'b0, 8'h20, 32'h0);
        chk("unmapped", 32'h0, rd);
        chk("hresp", 32'h0, {31'h0, hresp});
        // a write while the clock enable is low must be lost
        @(posedge hclk);
        ce_in <= 1'b0;
        bus(1'b1, IDX_NAT_SEL, 32'h1f);
        ce_in <= 1'b1;
        bus(1'b0, IDX_NAT_SEL, 32'h0);
        chk("nat_sel_frozen", {27'h0, NAT_SEL_RST}, rd);
    endtask

    task automatic t_status();
        for (int s = 0; s < 2; s++) begin
            bus(1'b1, IDX_CTRL, 32'(s) << CTRL_SRC_SEL_BIT);
            for (int f = 0; f < 4; f++) begin
                @(posedge hclk);
                loss_flag <= f[0];
                frame_flag <= f[1];
                bus(1'b0, IDX_LINE_STAT, 32'h0);
                chk("line_stat", {27'h0, f[0], 3'h0, f[1]}, rd);
                chk("loss_status_out", {31'h0, f[0] | (s == 0 && f[1])}, {31'h0, loss_out});
            end
        end
        @(posedge hclk);
        loss_flag <= 1'b0;
        frame_flag <= 1'b0;
    endtask

    task automatic t_alarm();
        @(posedge hclk);
        alarm_n <= 1'b0;
        repeat (8) @(posedge line_clk);
        for (int i = 0; i < 16; i++) begin
            @(posedge line_clk);
            chk("alarm_mark", 32'h1, {31'h0, pos | neg});
        end
        @(posedge hclk);
        alarm_n <= 1'b1;
    endtask

    // a window of two frames holds exactly one pulse per enabled slot
    task automatic t_link(input logic [4:0] sel, input int exp);
        bus(1'b1, IDX_NAT_SEL, {27'h0, sel});
        repeat (64) @(posedge line_clk);
        pulses = 0;
        chk_en = 1'b1;
        repeat (2 * FRAME_BITS) @(posedge line_clk);
        chk_en = 1'b0;
        chk("gapped_pulses", exp, pulses);
    endtask

    task automatic t_irq();
        bus(1'b1, IDX_IRQ_CLR, 32'h7);
        bus(1'b0, IDX_IRQ_STAT, 32'h0);
        chk("irq_stat_clr", 32'h0, rd);
        bus(1'b1, IDX_IRQ_EN, 32'h1);
        loss_flag <= 1'b1;
        repeat (4) @(posedge hclk);
        chk("irq_raised", 32'h1, {31'h0, irq});
        bus(1'b1, IDX_IRQ_EN, 32'h0);
        // the enable lands at the edge that ends the bus task; look one edge later
        @(posedge hclk);
        chk("irq_masked", 32'h0, {31'h0, irq});
        loss_flag <= 1'b0;
        bus(1'b1, IDX_IRQ_EN, 32'h1);
        @(posedge hclk);
        chk("irq_held", 32'h1, {31'h0, irq});
        bus(1'b1, IDX_IRQ_CLR, 32'h1);
        @(posedge hclk);
        chk("irq_cleared", 32'h0, {31'h0, irq});
    endtask

    task automatic t_mode();
        logic [1:0] m;
        for (int p = 0; p < 4; p++) begin
            @(posedge hclk);
            tm_sel <= p[1];
            ss_sel <= p[0];
            repeat (6) @(posedge hclk);
            // one edge on the clock pin; only bus sync may report it
            ext_clk <= 1'b1;
            repeat (4) @(posedge hclk);
            ext_clk <= 1'b0;
            m = p[1] ? {p[0], ~p[0]} : 2'b00;
            bus(1'b0, IDX_MODE_STAT, 32'h0);
            chk("mode_stat", {28'h0, p == 3, ~(p[1] & p[0]), m}, rd & 32'hf);
            chk("clk_oe", {31'h0, ~(p[1] & p[0])}, {31'h0, clk4_oe});
        end
        gen_clk <= 1'b1;
        repeat (2) @(posedge hclk);
        chk("clk4_o_high", 32'h1, {31'h0, clk4_o});
        gen_clk <= 1'b0;
        repeat (2) @(posedge hclk);
        chk("clk4_o_low", 32'h0, {31'h0, clk4_o});
        bus(1'b0, IDX_IRQ_STAT, 32'h0);
        chk("irq_mode_event", 32'h1 << EV_MODE, rd);
    endtask

    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_status();
        t_alarm();
        t_link(5'h01, 1);
        t_link(5'h1f, 5);
        t_link(5'h0a, 2);
        t_irq();
        t_mode();
        complete_run();
    end
endmodule
